// ==== core/uwr_core.sv ====
// Serial receiver with two-frame buffer, Avalon-MM registers and deferred transmitter disable
// Summary of operation
// - Cleared transmit enable takes effect only after shift register and buffer drain.
// - Once transmitter is really disabled, the transmit pin override is dropped.
// - While receive enable is set, the receive pin is owned by the receiver.
// - In synchronous mode bits are sampled on the external transfer clock.
// - Reception starts on a valid start bit; bits sampled and shifted to stop.
// - Any second stop bit is ignored; only the first stop bit counts.
// - On the first stop bit the frame moves into the receive buffer.
// - Unused upper data bits read as zero for characters below eight bits.
// - Nine-bit mode presents the stored ninth bit in control register B.
// - Each data read advances the buffer; status then shows the next frame.
// - Receive-complete flag is one exactly while unread frames are buffered.
// - Interrupt request stands while flag, its enable and global enable are set.
// - Frame, overrun and parity errors are stored per frame, read in status A.
// - Error flags ignore software writes and never request an interrupt.
// - Frame error is one when the first stop bit sampled zero.
// - Overrun when buffer full, a frame waits, and a new start bit arrives.
// - Overrun flag clears when a frame moves successfully into the buffer.
// - With parity enabled, received parity is checked and stored with the frame.
// - Parity error reads zero for frames received with parity checking off.
// - Clearing receive enable aborts reception, empties buffer, releases the pin.
`timescale 1ns/1ns
module uwr_core
  import uwr_pkg::*;
(
  // Clock and reset
  input  wire logic          CLK_IN,
  input  wire logic          RESET_N_IN,
  // Avalon-MM slave
  input  wire uwr_avs_req_t  AVS_REQ_IN,
  output uwr_avs_rsp_t       AVS_RSP_OUT,
  // CPU side
  input  wire logic          GLOBAL_IRQ_ENABLE_IN,
  output logic               RX_COMPLETE_IRQ_OUT,
  // Serial pins
  input  wire logic          SERIAL_IN_PIN_IN,
  input  wire logic          EXT_TRANSFER_CLOCK_PIN_IN,
  output logic               SERIAL_IN_PIN_OWNED_OUT,
  output logic               SERIAL_OUT_PIN_OUT,
  output logic               SERIAL_OUT_PIN_OE_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic [7:0]            csb;
    logic [7:0]            csc;
    logic [15:0]           baud;
    uwr_rx_state_t         rx_st;
    logic [15:0]           rx_cnt;
    logic [3:0]            rx_idx;
    logic [8:0]            rx_shift;
    logic                  rx_par;
    logic                  line_prev;
    logic                  xck_prev;
    logic                  hold;
    uwr_entry_t            hold_ent;
    logic                  ovr_pend;
    uwr_entry_t [1:0]      fifo;
    logic                  wp;
    logic                  rp;
    logic [1:0]            cnt;
    logic [7:0]            tx_buf;
    logic                  tx_full;
    logic [9:0]            tx_sh;
    logic [3:0]            tx_bits;
    logic [15:0]           tx_cnt;
    logic                  tx_active;
  } uwr_state_t;

  uwr_state_t s_q;
  uwr_state_t s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    if (code == UWR_SZ_NINE) begin
      data_bits = 4'h9;
    end else begin
      data_bits = 4'h5 + {2'h0, code[1:0]};
    end
  endfunction

  function automatic logic [7:0] size_mask(input logic [2:0] code);
    logic [3:0] nb;
    nb = data_bits(code);
    if (nb >= 4'h8) begin
      size_mask = 8'hff;
    end else begin
      size_mask = 8'((9'h001 << nb) - 9'h001);
    end
  endfunction

  logic       req;
  logic       do_wr;
  logic       do_rd_data;
  logic       rx_en;
  logic       tx_en;
  logic       sync_mode;
  logic       par_en;
  logic [2:0] size_code;
  logic       xck_rise;
  logic       sample;
  logic       start_ok;
  logic       push;
  logic       pop;
  logic       line;
  uwr_entry_t head;
  logic [7:0] rd_byte;

  assign req        = AVS_REQ_IN.read | AVS_REQ_IN.write;
  assign do_wr      = AVS_REQ_IN.write & s_q.ack;
  assign do_rd_data = AVS_REQ_IN.read & s_q.ack & (AVS_REQ_IN.address == UWR_OFF_DATA);
  assign rx_en      = s_q.csb[UWR_CSB_RXEN];
  assign tx_en      = s_q.csb[UWR_CSB_TX_ENABLE];
  assign sync_mode  = s_q.csc[UWR_CSC_SYNC];
  assign par_en     = s_q.csc[UWR_CSC_PAREN];
  assign size_code  = {s_q.csb[UWR_CSB_SZ2], s_q.csc[UWR_CSC_SZLO+1:UWR_CSC_SZLO]};
  assign line       = SERIAL_IN_PIN_IN;
  assign xck_rise   = EXT_TRANSFER_CLOCK_PIN_IN & ~s_q.xck_prev;
  // Bit clock: external edge in synchronous mode, else the baud counter
  assign sample     = sync_mode ? xck_rise : (s_q.rx_cnt == 16'h0000);
  assign push       = s_q.hold & (s_q.cnt < UWR_BUF_DEPTH);
  assign pop        = do_rd_data & (s_q.cnt != 2'h0);
  assign head       = (s_q.cnt != 2'h0) ? s_q.fifo[s_q.rp] : '0;
  assign start_ok   = rx_en & ((s_q.rx_st == RX_IDLE & sync_mode & xck_rise & ~line) |
                               (s_q.rx_st == RX_START & ~sync_mode & sample & ~line));

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    if (AVS_REQ_IN.address == UWR_OFF_DATA) begin
      rd_byte = head.data;
    end else if (AVS_REQ_IN.address == UWR_OFF_CSA) begin
      rd_byte = '0;
      rd_byte[UWR_CSA_RXC] = (s_q.cnt != 2'h0);
      rd_byte[UWR_CSA_TXE] = ~s_q.tx_full;
      rd_byte[UWR_CSA_FE]  = head.fe;
      rd_byte[UWR_CSA_DOR] = head.dor;
      rd_byte[UWR_CSA_PE]  = head.pe;
    end else if (AVS_REQ_IN.address == UWR_OFF_CSB) begin
      rd_byte = s_q.csb;
      rd_byte[UWR_CSB_RXB9] = head.b9;
    end else if (AVS_REQ_IN.address == UWR_OFF_CSC) begin
      rd_byte = s_q.csc;
    end else begin
      rd_byte = '0;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Bus: one wait state, read data captured before the accepting edge
    s_d.ack = req & ~s_q.ack;
    if (AVS_REQ_IN.address == UWR_OFF_BAUD) begin
      s_d.rdata = {16'h0000, s_q.baud};
    end else begin
      s_d.rdata = {24'h000000, rd_byte};
    end

    // Register writes; status A holds no writable bit
    if (do_wr) begin
      if (AVS_REQ_IN.address == UWR_OFF_CSB && AVS_REQ_IN.byteenable[0]) begin
        s_d.csb = AVS_REQ_IN.writedata[7:0] & UWR_CSB_WMASK;
      end else if (AVS_REQ_IN.address == UWR_OFF_CSC && AVS_REQ_IN.byteenable[0]) begin
        s_d.csc = AVS_REQ_IN.writedata[7:0] & UWR_CSC_WMASK;
      end else if (AVS_REQ_IN.address == UWR_OFF_BAUD) begin
        if (AVS_REQ_IN.byteenable[0]) begin
          s_d.baud[7:0] = AVS_REQ_IN.writedata[7:0];
        end
        if (AVS_REQ_IN.byteenable[1]) begin
          s_d.baud[15:8] = AVS_REQ_IN.writedata[15:8];
        end
      end else if (AVS_REQ_IN.address == UWR_OFF_DATA && AVS_REQ_IN.byteenable[0] &&
                   tx_en && !s_q.tx_full) begin
        s_d.tx_buf  = AVS_REQ_IN.writedata[7:0];
        s_d.tx_full = 1'b1;
      end
    end

    // Transmitter: plain shift out, kept alive until drained
    if (s_q.tx_bits == 4'h0) begin
      if (s_q.tx_full && s_q.tx_active) begin
        s_d.tx_sh   = {1'b1, s_q.tx_buf, 1'b0};
        s_d.tx_bits = UWR_TX_BITS;
        s_d.tx_cnt  = s_q.baud;
        s_d.tx_full = 1'b0;
      end
    end else if (s_q.tx_cnt == 16'h0000) begin
      s_d.tx_sh   = {1'b1, s_q.tx_sh[9:1]};
      s_d.tx_bits = s_q.tx_bits - 4'h1;
      s_d.tx_cnt  = s_q.baud;
    end else begin
      s_d.tx_cnt = s_q.tx_cnt - 16'h0001;
    end
    s_d.tx_active = tx_en | (s_q.tx_active & (s_q.tx_full | (s_q.tx_bits != 4'h0)));

    // Receiver sampling
    s_d.line_prev = line;
    s_d.xck_prev  = EXT_TRANSFER_CLOCK_PIN_IN;
    if (!sync_mode && s_q.rx_st != RX_IDLE) begin
      s_d.rx_cnt = sample ? s_q.baud : s_q.rx_cnt - 16'h0001;
    end
    case (s_q.rx_st)
      RX_IDLE: begin
        if (rx_en && sync_mode && xck_rise && !line) begin
          s_d.rx_st  = RX_DATA;
          s_d.rx_idx = 4'h0;
        end else if (rx_en && !sync_mode && !line && s_q.line_prev) begin
          s_d.rx_st  = RX_START;
          s_d.rx_cnt = {1'b0, s_q.baud[15:1]};
        end
      end
      RX_START: begin
        if (sample) begin
          s_d.rx_st  = line ? RX_IDLE : RX_DATA;
          s_d.rx_idx = 4'h0;
        end
      end
      RX_DATA: begin
        if (sample) begin
          s_d.rx_shift[s_q.rx_idx] = line;
          if (s_q.rx_idx == data_bits(size_code) - 4'h1) begin
            s_d.rx_st = par_en ? RX_PAR : RX_STOP;
          end else begin
            s_d.rx_idx = s_q.rx_idx + 4'h1;
          end
        end
      end
      RX_PAR: begin
        if (sample) begin
          s_d.rx_par = line;
          s_d.rx_st  = RX_STOP;
        end
      end
      RX_STOP: begin
        // Only the first stop bit is looked at
        if (sample) begin
          s_d.rx_st         = RX_IDLE;
          s_d.hold          = 1'b1;
          s_d.hold_ent.dor  = 1'b0;
          s_d.hold_ent.fe   = ~line;
          s_d.hold_ent.pe   = par_en & ((^(s_q.rx_shift & {size_code == UWR_SZ_NINE, size_mask(size_code)}) ^ s_q.rx_par) !=
                                        s_q.csc[UWR_CSC_PODD]);
          s_d.hold_ent.b9   = (size_code == UWR_SZ_NINE) & s_q.rx_shift[8];
          s_d.hold_ent.data = s_q.rx_shift[7:0] & size_mask(size_code);
        end
      end
      default: begin
        s_d.rx_st = RX_IDLE;
      end
    endcase

    // Overrun: the waiting frame is lost to the new one
    if (start_ok && s_q.hold && s_q.cnt == UWR_BUF_DEPTH) begin
      s_d.ovr_pend = 1'b1;
      s_d.hold     = 1'b0;
    end

    // Buffer move and read
    if (push) begin
      s_d.fifo[s_q.wp]     = s_q.hold_ent;
      s_d.fifo[s_q.wp].dor = s_q.ovr_pend;
      s_d.wp               = ~s_q.wp;
      s_d.hold             = s_q.hold & (s_d.rx_st == RX_IDLE) & (s_q.rx_st == RX_STOP);
      s_d.ovr_pend         = 1'b0;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};

    // Receiver off: everything in flight or buffered is dropped
    if (!s_d.csb[UWR_CSB_RXEN]) begin
      s_d.rx_st    = RX_IDLE;
      s_d.hold     = 1'b0;
      s_d.ovr_pend = 1'b0;
      s_d.cnt      = 2'h0;
      s_d.wp       = s_q.rp;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      s_q         <= '0;
      s_q.csb     <= UWR_CSB_RST;
      s_q.csc     <= UWR_CSC_RST;
      s_q.baud    <= UWR_BAUD_RST;
      s_q.rx_st   <= RX_IDLE;
      s_q.tx_sh   <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AVS_RSP_OUT.waitrequest = req & ~s_q.ack;
  assign AVS_RSP_OUT.readdata    = s_q.rdata;
  assign RX_COMPLETE_IRQ_OUT     = s_q.csb[UWR_CSB_RXCIE] & GLOBAL_IRQ_ENABLE_IN & (s_q.cnt != 2'h0);
  assign SERIAL_IN_PIN_OWNED_OUT = rx_en;
  assign SERIAL_OUT_PIN_OUT      = s_q.tx_sh[0];
  assign SERIAL_OUT_PIN_OE_OUT   = s_q.tx_active;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence s_stop_sample;
    s_q.rx_st == RX_STOP && sample && rx_en;
  endsequence

  sequence s_drained_off;
    !tx_en && !s_q.tx_full && s_q.tx_bits == 4'h0;
  endsequence

  a_tx_keep_busy: assert property (
    s_q.tx_active && !tx_en && (s_q.tx_full || s_q.tx_bits != 4'h0) |=> SERIAL_OUT_PIN_OE_OUT)
    else $error("transmitter dropped before draining");

  a_tx_pin_free: assert property (s_drained_off ##1 s_drained_off |-> !SERIAL_OUT_PIN_OE_OUT)
    else $error("transmit pin still overridden after disable");

  a_rx_pin_owned: assert property (s_q.rx_st != RX_IDLE |-> SERIAL_IN_PIN_OWNED_OUT)
    else $error("receiver active without owning the pin");

  a_sync_no_edge: assert property (
    sync_mode && s_q.rx_st == RX_DATA && !xck_rise && rx_en |=> $stable(s_q.rx_idx) && $stable(s_q.rx_shift))
    else $error("synchronous receiver advanced without clock edge");

  a_stop_frame_err: assert property (
    s_stop_sample |=> s_q.hold && s_q.hold_ent.fe == !$past(line))
    else $error("frame error not taken from first stop bit");

  a_parity_off: assert property ((s_stop_sample and !par_en) |=> !s_q.hold_ent.pe)
    else $error("parity error stored with checking off");

  a_size_mask: assert property (
    s_q.hold |-> (s_q.hold_ent.data & ~size_mask(size_code)) == 8'h00 || $changed(size_code))
    else $error("unused data bits not zero");

  a_irq_flag: assert property (RX_COMPLETE_IRQ_OUT |-> s_q.cnt != 2'h0 && s_q.csb[UWR_CSB_RXCIE])
    else $error("interrupt without buffered frame");

  a_pop_advance: assert property (pop && !push && rx_en |=> s_q.cnt == $past(s_q.cnt) - 2'h1)
    else $error("data read did not advance buffer");

  a_rx_flush: assert property (!rx_en |=> s_q.cnt == 2'h0 && s_q.rx_st == RX_IDLE && !s_q.hold)
    else $error("receiver disable did not flush");

  a_bus_answer: assert property (req && !s_q.ack |=> !AVS_RSP_OUT.waitrequest || !req)
    else $error("bus answer later than one wait state");

  a_err_no_write: assert property (
    do_wr && AVS_REQ_IN.address == UWR_OFF_CSA && !push && !pop |=> $stable(s_q.fifo))
    else $error("status A write altered stored flags");

endmodule

// ==== core/uwr_pkg.sv ====
// Package for the serial receiver with deferred transmitter disable
package uwr_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam int            UWR_ADDR_W     = 5;
  localparam logic [4:0]    UWR_OFF_DATA   = 5'h00;
  localparam logic [4:0]    UWR_OFF_CSA    = 5'h04;
  localparam logic [4:0]    UWR_OFF_CSB    = 5'h08;
  localparam logic [4:0]    UWR_OFF_CSC    = 5'h0c;
  localparam logic [4:0]    UWR_OFF_BAUD   = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int            UWR_CSA_RXC    = 7;
  localparam int            UWR_CSA_TXE    = 5;
  localparam int            UWR_CSA_FE     = 4;
  localparam int            UWR_CSA_DOR    = 3;
  localparam int            UWR_CSA_PE     = 2;
  localparam int            UWR_CSB_RXCIE  = 7;
  localparam int            UWR_CSB_RXEN   = 4;
  localparam int            UWR_CSB_TX_ENABLE   = 3;
  localparam int            UWR_CSB_SZ2    = 2;
  localparam int            UWR_CSB_RXB9   = 1;
  localparam int            UWR_CSB_TXB9   = 0;
  localparam int            UWR_CSC_SYNC   = 6;
  localparam int            UWR_CSC_PAREN  = 5;
  localparam int            UWR_CSC_PODD   = 4;
  localparam int            UWR_CSC_STOP2  = 3;
  localparam int            UWR_CSC_SZLO   = 1;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]    UWR_CSB_RST    = 8'h00;
  localparam logic [7:0]    UWR_CSC_RST    = 8'h06;
  localparam logic [7:0]    UWR_CSB_WMASK  = 8'hfd;
  localparam logic [7:0]    UWR_CSC_WMASK  = 8'h7e;
  localparam logic [15:0]   UWR_BAUD_RST   = 16'h0363;
  localparam logic [2:0]    UWR_SZ_NINE    = 3'h7;
  localparam logic [3:0]    UWR_TX_BITS    = 4'ha;
  localparam logic [1:0]    UWR_BUF_DEPTH  = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uwr_rx_state_t;

  typedef struct packed {
    logic       dor;
    logic       fe;
    logic       pe;
    logic       b9;
    logic [7:0] data;
  } uwr_entry_t;

  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [UWR_ADDR_W-1:0] address;
    logic [3:0]            byteenable;
    logic [31:0]           writedata;
  } uwr_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } uwr_avs_rsp_t;

endpackage

// ==== dv/uwr_serial_tx_model.sv ====
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ns
module uwr_serial_tx_model #(
  parameter int BIT_CLKS = 4
) (
  // Clock
  input  wire logic clk_in,
  // Serial pins
  output logic      line_out,
  output logic      xck_out
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  initial begin
    line_out = 1'b1;
    xck_out  = 1'b0;
  end

  // Sync bits raise the transfer clock mid-bit; it stands low between frames
  task automatic put_bit(input logic b, input logic sync);
    line_out <= b;
    if (sync) begin
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      xck_out <= 1'b1;
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      xck_out <= 1'b0;
    end else begin
      repeat (BIT_CLKS) @(posedge clk_in);
    end
  endtask

  // Start, data LSB first, optional parity, one stop bit, one idle bit
  task automatic send(input logic [8:0] d, input int n, input logic par_en, input logic par_bit,
                      input logic stop, input logic sync);
    @(posedge clk_in);
    put_bit(1'b0, sync);
    for (int i = 0; i < n; i++) begin
      put_bit(d[i], sync);
    end
    if (par_en) begin
      put_bit(par_bit, sync);
    end
    put_bit(stop, sync);
    put_bit(1'b1, 1'b0);
  endtask
endmodule

// ==== dv/tb_uart_receiver_with_tx_disable.sv ====
// Self-checking testbench for the serial receiver with deferred transmitter disable
`timescale 1ns/1ns
module tb_uart_receiver_with_tx_disable
  import uwr_pkg::*;
;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  logic         clk    = 1'b0;
  logic         rst_n  = 1'b0;
  logic         glob   = 1'b1;
  uwr_avs_req_t req    = '0;
  uwr_avs_rsp_t rsp;
  logic         rx_line;
  logic         xck;
  logic         irq;
  logic         owned;
  logic         tx_line;
  logic         tx_oe;
  logic [15:0]  rd;
  int           mismatches   = 0;
  int           total_checks = 0;
  int           cycles       = 0;

  always #5 clk = ~clk;

  uwr_core uut (.CLK_IN(clk), .RESET_N_IN(rst_n), .AVS_REQ_IN(req), .AVS_RSP_OUT(rsp),
    .GLOBAL_IRQ_ENABLE_IN(glob), .RX_COMPLETE_IRQ_OUT(irq), .SERIAL_IN_PIN_IN(rx_line),
    .EXT_TRANSFER_CLOCK_PIN_IN(xck), .SERIAL_IN_PIN_OWNED_OUT(owned),
    .SERIAL_OUT_PIN_OUT(tx_line), .SERIAL_OUT_PIN_OE_OUT(tx_oe));

  // Bit time of 4 clocks matches a divisor of 3
  uwr_serial_tx_model #(.BIT_CLKS(4)) u_tx (.clk_in(clk), .line_out(rx_line), .xck_out(xck));

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low; read data stands in that cycle
  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [15:0] wd);
    @(posedge clk);
    req.read       <= ~wr_en;
    req.write      <= wr_en;
    req.address    <= a;
    req.byteenable <= (a == UWR_OFF_BAUD) ? 4'h3 : 4'h1;
    req.writedata  <= {16'h0000, wd};
    do begin
      @(posedge clk);
    end while (rsp.waitrequest !== 1'b0);
    rd = rsp.readdata[15:0];
    req.read  <= 1'b0;
    req.write <= 1'b0;
    // Let the accepting edge settle before any caller looks at outputs
    @(negedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({13'h0, owned, tx_oe, tx_line}, 16'h0001);
    rdchk(UWR_OFF_CSB, 16'h0000);
    rdchk(UWR_OFF_CSC, 16'h0006);
    rdchk(UWR_OFF_BAUD, 16'h0363);
    rdchk(5'h14, 16'h0000);
    rdchk(UWR_OFF_CSA, 16'h0020);
  endtask

  task automatic t_basic();
    wr(UWR_OFF_BAUD, 16'h0003);
    wr(UWR_OFF_CSB, 16'h0090);
    chk(owned, 1'b1);
    u_tx.send(9'h0a5, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    @(negedge clk);
    chk(irq, 1'b1);
    @(posedge clk);
    glob <= 1'b0;
    @(negedge clk);
    chk(irq, 1'b0);
    @(posedge clk);
    glob <= 1'b1;
    rdchk(UWR_OFF_CSA, 16'h00a0);
    rdchk(UWR_OFF_DATA, 16'h00a5);
    rdchk(UWR_OFF_CSA, 16'h0020);
    chk(irq, 1'b0);
  endtask

  task automatic t_sizes();
    for (int c = 0; c < 4; c++) begin
      wr(UWR_OFF_CSC, 16'(c << 1));
      u_tx.send(9'h1ff, c + 5, 1'b0, 1'b0, 1'b1, 1'b0);
      rdchk(UWR_OFF_DATA, 16'h00ff >> (3 - c));
    end
  endtask

  task automatic t_nine();
    wr(UWR_OFF_CSC, 16'h0006);
    wr(UWR_OFF_CSB, 16'h0094);
    u_tx.send(9'h13c, 9, 1'b0, 1'b0, 1'b1, 1'b0);
    u_tx.send(9'h0c3, 9, 1'b0, 1'b0, 1'b1, 1'b0);
    rdchk(UWR_OFF_CSB, 16'h0096);
    rdchk(UWR_OFF_DATA, 16'h003c);
    rdchk(UWR_OFF_CSB, 16'h0094);
    rdchk(UWR_OFF_DATA, 16'h00c3);
    wr(UWR_OFF_CSB, 16'h0090);
  endtask

  // Good parity then bad parity, in even and odd mode
  task automatic t_parity();
    for (int o = 0; o < 2; o++) begin
      wr(UWR_OFF_CSC, 16'h0026 | 16'(o << 4));
      u_tx.send(9'h0b4, 8, 1'b1, ^8'hb4 ^ o[0], 1'b1, 1'b0);
      u_tx.send(9'h0b4, 8, 1'b1, ~(^8'hb4 ^ o[0]), 1'b1, 1'b0);
      rdchk(UWR_OFF_CSA, 16'h00a0);
      rdchk(UWR_OFF_DATA, 16'h00b4);
      rdchk(UWR_OFF_CSA, 16'h00a4);
      rdchk(UWR_OFF_DATA, 16'h00b4);
    end
  endtask

  task automatic t_frame();
    wr(UWR_OFF_CSC, 16'h000e);
    u_tx.send(9'h05a, 8, 1'b0, 1'b0, 1'b0, 1'b0);
    u_tx.send(9'h05b, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    rdchk(UWR_OFF_CSA, 16'h00b0);
    wr(UWR_OFF_CSA, 16'h0000);
    rdchk(UWR_OFF_CSA, 16'h00b0);
    rdchk(UWR_OFF_DATA, 16'h005a);
    rdchk(UWR_OFF_CSA, 16'h00a0);
    rdchk(UWR_OFF_DATA, 16'h005b);
    wr(UWR_OFF_CSC, 16'h0006);
  endtask

  // Four frames unread: the third is lost when the fourth starts
  task automatic t_overrun();
    for (int i = 0; i < 4; i++) begin
      u_tx.send(9'(8'h10 + i), 8, 1'b0, 1'b0, 1'b1, 1'b0);
    end
    rdchk(UWR_OFF_CSA, 16'h00a0);
    rdchk(UWR_OFF_DATA, 16'h0010);
    rdchk(UWR_OFF_CSA, 16'h00a0);
    rdchk(UWR_OFF_DATA, 16'h0011);
    rdchk(UWR_OFF_CSA, 16'h00a8);
    rdchk(UWR_OFF_DATA, 16'h0013);
    u_tx.send(9'h014, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    rdchk(UWR_OFF_CSA, 16'h00a0);
    rdchk(UWR_OFF_DATA, 16'h0014);
    rdchk(UWR_OFF_CSA, 16'h0020);
  endtask

  // Disable with one frame stored and another in flight
  task automatic t_rx_off();
    u_tx.send(9'h0aa, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    fork
      u_tx.send(9'h0ff, 8, 1'b0, 1'b0, 1'b1, 1'b0);
      begin
        repeat (8) @(posedge clk);
        wr(UWR_OFF_CSB, 16'h0080);
        @(negedge clk);
        chk({owned, irq}, 16'h0000);
        wr(UWR_OFF_CSB, 16'h0090);
      end
    join
    rdchk(UWR_OFF_CSA, 16'h0020);
  endtask

  task automatic t_sync();
    wr(UWR_OFF_CSC, 16'h0046);
    u_tx.send(9'h069, 8, 1'b0, 1'b0, 1'b1, 1'b1);
    rdchk(UWR_OFF_DATA, 16'h0069);
    rdchk(UWR_OFF_CSA, 16'h0020);
    wr(UWR_OFF_CSC, 16'h0006);
  endtask

  // Two queued bytes keep the transmitter alive after its enable is cleared
  task automatic t_tx_off();
    int n;
    wr(UWR_OFF_CSB, 16'h0098);
    wr(UWR_OFF_DATA, 16'h0055);
    wr(UWR_OFF_DATA, 16'h00aa);
    wr(UWR_OFF_CSB, 16'h0090);
    @(negedge clk);
    chk(tx_oe, 1'b1);
    n = 0;
    while (tx_oe === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(n > 60, 1'b1);
    chk({tx_oe, tx_line}, 16'h0001);
    wr(UWR_OFF_DATA, 16'h0033);
    @(negedge clk);
    chk(tx_oe, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_basic();
    t_sizes();
    t_nine();
    t_parity();
    t_frame();
    t_overrun();
    t_rx_off();
    t_sync();
    t_tx_off();
    summarize();
  end
endmodule
